// ---- common/mdr_defs.svh ----
// register offsets, field positions and reset values for the mac/dma map
// assumes inclusion by bare name from the design file
`ifndef MDR_DEFS_SVH
`define MDR_DEFS_SVH
`define MDR_OFF_AF30L 16'h0874
`define MDR_OFF_AF31H 16'h0878
`define MDR_OFF_AF31L 16'h087C
`define MDR_OFF_BUSCFG 16'h1000
`define MDR_OFF_TXPOLL 16'h1004
`define MDR_OFF_RXPOLL 16'h1008
`define MDR_OFF_RXBASE 16'h100C
`define MDR_OFF_TXBASE 16'h1010
`define MDR_OFF_STATUS 16'h1014
`define MDR_OFF_OPCFG 16'h1018
`define MDR_OFF_IRQEN 16'h101C
`define MDR_OFF_MISSED 16'h1020
`define MDR_OFF_RXWDT 16'h1024
`define MDR_OFF_BUSSTAT 16'h102C
`define MDR_OFF_CURTXD 16'h1048
`define MDR_OFF_CURRXD 16'h104C
`define MDR_OFF_CURTXB 16'h1050
`define MDR_OFF_CURRXB 16'h1054
`define MDR_OFF_EVTSTAT 16'h1060
`define MDR_OFF_EVTCLR 16'h1064
`define MDR_OFF_EVTEN 16'h1068
`define MDR_OFF_SYSTIME 16'h106C
// field positions
`define MDR_BUSCFG_SWRST 0
`define MDR_OPCFG_RXSTART 1
`define MDR_OPCFG_TXSTART 13
`define MDR_MISSED_OVF 16
// reset values
`define MDR_RST_ZERO 32'h0000_0000
`define MDR_RST_AF_HIGH 32'h0000_FFFF
`define MDR_RST_AF_LOW 32'hFFFF_FFFF
`define MDR_RST_BUSCFG 32'h0002_0101
// event bits in the interrupt status register
`define MDR_EV_TXPOLL 0
`define MDR_EV_RXPOLL 1
`define MDR_EV_RESETDONE 2
`define MDR_EV_OVERFLOW 3
`define MDR_EV_BUSERR 4
`define MDR_EV_BITS 5
`endif

// ---- common/mdr_pkg.sv ----
// types for the mac/dma register block
// assumes the defs header is included where offsets are used
package mdr_pkg;
  typedef enum logic [1:0] {
    MDR_RESP_OKAY = 2'b00,
    MDR_RESP_SLVERR = 2'b10
  } mdr_resp_t;
endpackage : mdr_pkg

// ---- hdl/mdr_regs.sv ----
// axi4-lite register bank for the upper mac/dma register space
// assumes a single clock, synchronous inputs from the dma/mac core
`timescale 1ns/1ns
`include "mdr_defs.svh"

////////////////////////////////////////////////////////////////////////////
module mdr_regs
  import mdr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_done,
  input wire logic start_done,
  input wire logic overflow_event,
  input wire logic bus_error_event,
  input wire logic time_tick,
  input wire logic [31:0] bus_status_in,
  input wire logic [31:0] cur_tx_desc_in,
  input wire logic [31:0] cur_rx_desc_in,
  input wire logic [31:0] cur_tx_buf_in,
  input wire logic [31:0] cur_rx_buf_in,
  output logic tx_poll_pulse,
  output logic rx_poll_pulse,
  output logic soft_reset,
  output logic [31:0] bus_config,
  output logic [31:0] operation_config,
  output logic [31:0] rx_desc_base,
  output logic [31:0] tx_desc_base,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture, address and data in either order
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go, rd_go;
  logic [ADDR_W-1:0] ar_addr;
  logic ar_held;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // ready only while the slot is empty and no response is pending
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid && !wr_go;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid && !wr_go;
    end
  end

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MDR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= MDR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [ADDR_W-1:0] wa;
  assign wa = {aw_addr[ADDR_W-1:2], 2'b00};
  logic wr_af30l, wr_af31h, wr_af31l, wr_bus, wr_txp, wr_rxp, wr_rxb;
  logic wr_txb, wr_op, wr_ien, wr_wdt, wr_eclr, wr_een, wr_time;
  assign wr_af30l = wr_go && wa == `MDR_OFF_AF30L;
  assign wr_af31h = wr_go && wa == `MDR_OFF_AF31H;
  assign wr_af31l = wr_go && wa == `MDR_OFF_AF31L;
  assign wr_bus = wr_go && wa == `MDR_OFF_BUSCFG;
  assign wr_txp = wr_go && wa == `MDR_OFF_TXPOLL;
  assign wr_rxp = wr_go && wa == `MDR_OFF_RXPOLL;
  assign wr_rxb = wr_go && wa == `MDR_OFF_RXBASE;
  assign wr_txb = wr_go && wa == `MDR_OFF_TXBASE;
  assign wr_op = wr_go && wa == `MDR_OFF_OPCFG;
  assign wr_ien = wr_go && wa == `MDR_OFF_IRQEN;
  assign wr_wdt = wr_go && wa == `MDR_OFF_RXWDT;
  assign wr_eclr = wr_go && wa == `MDR_OFF_EVTCLR;
  assign wr_een = wr_go && wa == `MDR_OFF_EVTEN;
  assign wr_time = wr_go && wa == `MDR_OFF_SYSTIME;
  logic wr_stat;
  assign wr_stat = wr_go && wa == `MDR_OFF_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // plain read/write storage
  logic [31:0] af30l, af31h, af31l, irq_en_reg, wdt_reg, time_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      af30l <= `MDR_RST_AF_LOW;
      af31h <= `MDR_RST_AF_HIGH;
      af31l <= `MDR_RST_AF_LOW;
    end else begin
      if (wr_af30l) af30l <= merge(af30l, w_data, w_strb);
      if (wr_af31h) af31h <= merge(af31h, w_data, w_strb);
      if (wr_af31l) af31l <= merge(af31l, w_data, w_strb);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_desc_base <= `MDR_RST_ZERO;
      tx_desc_base <= `MDR_RST_ZERO;
      irq_en_reg <= `MDR_RST_ZERO;
      wdt_reg <= `MDR_RST_ZERO;
    end else begin
      if (wr_rxb) rx_desc_base <= merge(rx_desc_base, w_data, w_strb);
      if (wr_txb) tx_desc_base <= merge(tx_desc_base, w_data, w_strb);
      if (wr_ien) irq_en_reg <= merge(irq_en_reg, w_data, w_strb);
      if (wr_wdt) wdt_reg <= merge(wdt_reg, w_data, w_strb);
    end
  end

  // system time: software write wins, else ticks advance it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      time_reg <= `MDR_RST_ZERO;
    end else if (wr_time) begin
      time_reg <= merge(time_reg, w_data, w_strb);
    end else if (time_tick) begin
      time_reg <= time_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus config with the software reset request bit
  // set by one, zero ignored, cleared when reset completes (a bus config write in that cycle wins)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_config <= `MDR_RST_BUSCFG;
    end else begin
      if (wr_bus) begin
        bus_config <= merge(bus_config, w_data, w_strb);
        bus_config[`MDR_BUSCFG_SWRST] <= bus_config[`MDR_BUSCFG_SWRST]
          | (w_strb[0] & w_data[`MDR_BUSCFG_SWRST]);
      end else if (reset_done) begin
        bus_config[`MDR_BUSCFG_SWRST] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) soft_reset <= 1'b0;
    else soft_reset <= bus_config[`MDR_BUSCFG_SWRST];
  end

  // start bits are rw, hardware clears only the tx start bit on completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      operation_config <= `MDR_RST_ZERO;
    end else if (wr_op) begin
      operation_config <= merge(operation_config, w_data, w_strb);
    end else if (start_done) begin
      operation_config[`MDR_OPCFG_TXSTART] <= 1'b0;
    end
  end

  // any write to a poll register fires its event
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_poll_pulse <= 1'b0;
      rx_poll_pulse <= 1'b0;
    end else begin
      tx_poll_pulse <= wr_txp;
      rx_poll_pulse <= wr_rxp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma status: bus error flag cleared by writing one (set wins)
  logic [31:0] dma_status;
  // write one clears, zero leaves it alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_status <= `MDR_RST_ZERO;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (i == `MDR_EV_BUSERR && bus_error_event) begin
          dma_status[i] <= 1'b1;
        end else if (wr_stat && w_strb[i/8] && w_data[i]) begin
          dma_status[i] <= 1'b0;
        end
      end
    end
  end

  // overflow-active flag: hardware sets/clears, write zero clears
  logic ovf_active;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ovf_active <= 1'b0;
    end else if (overflow_event) begin
      ovf_active <= 1'b1;
    end else if (reset_done) begin
      ovf_active <= 1'b0;
    end else if (wr_stat && w_strb[3] && !w_data[31]) begin
      ovf_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic [31:0] missed_cnt;
  logic rd_missed;
  assign rd_go = ar_held && !s_axi_rvalid;
  assign rd_missed = rd_go
    && {ar_addr[ADDR_W-1:2], 2'b00} == `MDR_OFF_MISSED;

  // count overflow events; whole register clears on read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      missed_cnt <= `MDR_RST_ZERO;
    end else if (overflow_event) begin
      // set wins over the read clear
      // the read returned the old count, so this event counts as the first
      missed_cnt <= rd_missed ? (32'h0001_0001)
        : {15'h0000, 1'b1, missed_cnt[15:0] + 16'h0001};
    end else if (rd_missed) begin
      missed_cnt <= `MDR_RST_ZERO;
    end
  end

  // interrupt status: sticky events, clear register, enable register
  logic [`MDR_EV_BITS-1:0] evt_stat, evt_en, evt_in;
  assign evt_in = {bus_error_event, overflow_event, reset_done,
                   rx_poll_pulse, tx_poll_pulse};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      evt_stat <= '0;
      evt_en <= '0;
    end else begin
      evt_stat <= evt_in | (evt_stat
        & ~(wr_eclr ? w_data[`MDR_EV_BITS-1:0] : '0));
      if (wr_een) evt_en <= w_data[`MDR_EV_BITS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) irq <= 1'b0;
    else irq <= |(evt_stat & evt_en);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ar_held <= 1'b0;
      ar_addr <= '0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !ar_held && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        ar_held <= 1'b1;
        ar_addr <= s_axi_araddr;
      end else if (rd_go) begin
        ar_held <= 1'b0;
      end
    end
  end

  // reserved addresses read zero; live pointers
  logic [31:0] next_rdata;
  always_comb begin
    unique case ({ar_addr[ADDR_W-1:2], 2'b00})
      `MDR_OFF_AF30L: next_rdata = af30l;
      `MDR_OFF_AF31H: next_rdata = af31h;
      `MDR_OFF_AF31L: next_rdata = af31l;
      `MDR_OFF_BUSCFG: next_rdata = bus_config;
      `MDR_OFF_TXPOLL: next_rdata = `MDR_RST_ZERO;
      `MDR_OFF_RXPOLL: next_rdata = `MDR_RST_ZERO;
      `MDR_OFF_RXBASE: next_rdata = rx_desc_base;
      `MDR_OFF_TXBASE: next_rdata = tx_desc_base;
      `MDR_OFF_STATUS: next_rdata = {ovf_active, dma_status[30:0]};
      `MDR_OFF_OPCFG: next_rdata = operation_config;
      `MDR_OFF_IRQEN: next_rdata = irq_en_reg;
      `MDR_OFF_MISSED: next_rdata = missed_cnt;
      `MDR_OFF_RXWDT: next_rdata = wdt_reg;
      `MDR_OFF_BUSSTAT: next_rdata = bus_status_in;
      `MDR_OFF_CURTXD: next_rdata = cur_tx_desc_in;
      `MDR_OFF_CURRXD: next_rdata = cur_rx_desc_in;
      `MDR_OFF_CURTXB: next_rdata = cur_tx_buf_in;
      `MDR_OFF_CURRXB: next_rdata = cur_rx_buf_in;
      `MDR_OFF_EVTSTAT: next_rdata = {27'h0, evt_stat};
      `MDR_OFF_EVTEN: next_rdata = {27'h0, evt_en};
      `MDR_OFF_SYSTIME: next_rdata = time_reg;
      default: next_rdata = `MDR_RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= MDR_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= MDR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // poll fires one cycle after the write
  a_tx_poll_fire: assert property (@(posedge mclk) disable iff (!resetn)
    wr_txp |=> tx_poll_pulse) else $error("tx poll missed");
  a_rx_poll_fire: assert property (@(posedge mclk) disable iff (!resetn)
    rx_poll_pulse |-> $past(wr_rxp)) else $error("rx poll spurious");
  a_read_clear: assert property (@(posedge mclk) disable iff (!resetn)
    rd_missed && !overflow_event |=> missed_cnt == 32'h0)
    else $error("counter not cleared");
  a_flag_set: assert property (@(posedge mclk) disable iff (!resetn)
    bus_error_event |=> dma_status[`MDR_EV_BUSERR])
    else $error("flag not set");
  a_reset_clear: assert property (@(posedge mclk) disable iff (!resetn)
    reset_done && !wr_bus |=> !bus_config[`MDR_BUSCFG_SWRST])
    else $error("reset bit stuck");
  a_ovf_keep: assert property (@(posedge mclk) disable iff (!resetn)
    ovf_active && !reset_done && !(wr_stat && w_strb[3] && !w_data[31])
    |=> ovf_active) else $error("ovf dropped");
  a_resv_zero: assert property (@(posedge mclk) disable iff (!resetn)
    rd_go && {ar_addr[ADDR_W-1:2], 2'b00} == 16'h1028
    |=> s_axi_rdata == 32'h0) else $error("reserved nonzero");
  a_time_tick: assert property (@(posedge mclk) disable iff (!resetn)
    time_tick && !wr_time |=> time_reg == $past(time_reg) + 32'h1)
    else $error("time stalled");
  // reset values
  // looked at one edge later: before the first edge the flops are unknown
  a_reset_vals: assert property (@(posedge mclk)
    !resetn |=> bus_config == `MDR_RST_BUSCFG && !irq)
    else $error("bad reset");

endmodule : mdr_regs

// ---- sim/mdr_regs_tb_top.sv ----
// self-checking bench for the mac/dma register bank
// assumes mdr_pkg compiled first and mdr_defs.svh on the include path
`timescale 1ns/1ns
`include "mdr_defs.svh"

////////////////////////////////////////////////////////////////////////////
module mdr_regs_tb_top import mdr_pkg::*;;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  // reset_done, start_done, overflow, bus error, time tick
  logic [4:0] ev = 5'h00;
  logic [31:0] ptr_in [0:4];
  logic tx_poll;
  logic rx_poll;
  logic soft_rst;
  logic irq;
  logic [31:0] bus_cfg;
  logic [31:0] op_cfg;
  logic [31:0] rx_base;
  logic [31:0] tx_base;
  int tx_n = 0;
  int rx_n = 0;
  int fails = 0;
  int check_count = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  mdr_regs dut (
    .mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .reset_done(ev[0]), .start_done(ev[1]),
    .overflow_event(ev[2]), .bus_error_event(ev[3]), .time_tick(ev[4]),
    .bus_status_in(ptr_in[0]), .cur_tx_desc_in(ptr_in[1]),
    .cur_rx_desc_in(ptr_in[2]), .cur_tx_buf_in(ptr_in[3]),
    .cur_rx_buf_in(ptr_in[4]), .tx_poll_pulse(tx_poll),
    .rx_poll_pulse(rx_poll), .soft_reset(soft_rst), .bus_config(bus_cfg),
    .operation_config(op_cfg), .rx_desc_base(rx_base),
    .tx_desc_base(tx_base), .irq(irq)
  );

  // count trigger pulses; a stretched pulse shows up as an extra count
  always @(posedge mclk) begin
    if (tx_poll === 1'b1) tx_n <= tx_n + 1;
    if (rx_poll === 1'b1) rx_n <= rx_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a wait that runs out ends the run
  task automatic give_up();
    fails++;
    $display("bus wait limit reached at %0t", $time);
    conclude();
  endtask : give_up

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    if (n >= 64) give_up();
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, MDR_RESP_OKAY});
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    if (n >= 64) give_up();
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, MDR_RESP_OKAY});
  endtask : rdchk

  task automatic pulse(input int b);
    @(posedge mclk);
    ev[b] <= 1'b1;
    @(posedge mclk);
    ev[b] <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(bus_cfg, 32'h0002_0101);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(`MDR_OFF_BUSCFG, 32'h0002_0101);
    rdchk(`MDR_OFF_AF30L, 32'hFFFF_FFFF);
    rdchk(`MDR_OFF_AF31H, 32'h0000_FFFF);
    rdchk(`MDR_OFF_STATUS, 32'h0000_0000);
    rdchk(`MDR_OFF_MISSED, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset

  // write all first, read all after, so aliased decodes show
  task automatic t_rw();
    logic [15:0] adr [0:6];
    adr = '{`MDR_OFF_AF30L, `MDR_OFF_AF31H, `MDR_OFF_AF31L,
            `MDR_OFF_RXBASE, `MDR_OFF_TXBASE, `MDR_OFF_IRQEN,
            `MDR_OFF_RXWDT};
    foreach (adr[i]) wr(adr[i], {adr[i], ~adr[i]});
    foreach (adr[i]) rdchk(adr[i], {adr[i], ~adr[i]});
    chk(rx_base, 32'h100C_EFF3);
    chk(tx_base, 32'h1010_EFEF);
    wr(`MDR_OFF_RXWDT, 32'h1122_3344, 4'b0010);
    rdchk(`MDR_OFF_RXWDT, 32'h1024_33DB);
    $display("read write test done");
  endtask : t_rw

  task automatic t_rsv();
    logic [15:0] adr [0:6];
    adr = '{16'h0880, 16'h0FFC, 16'h1028, 16'h1030, 16'h1044, 16'h1058,
            16'hFFFC};
    foreach (adr[i]) wr(adr[i], 32'hFFFF_FFFF);
    foreach (adr[i]) rdchk(adr[i], 32'h0000_0000);
    rdchk(`MDR_OFF_RXBASE, 32'h100C_EFF3);
    rdchk(`MDR_OFF_AF31L, 32'h087C_F783);
    $display("reserved test done");
  endtask : t_rsv

  task automatic t_poll();
    int t0;
    int r0;
    t0 = tx_n;
    r0 = rx_n;
    wr(`MDR_OFF_TXPOLL, 32'h0000_DEAD);
    wr(`MDR_OFF_TXPOLL, 32'h0000_0000);
    wr(`MDR_OFF_RXPOLL, 32'h0000_0000);
    idle(3);
    chk(32'(tx_n - t0), 32'h0000_0002);
    chk(32'(rx_n - r0), 32'h0000_0001);
    rdchk(`MDR_OFF_TXPOLL, 32'h0000_0000);
    $display("poll test done");
  endtask : t_poll

  task automatic t_swrst();
    pulse(0);
    rdchk(`MDR_OFF_BUSCFG, 32'h0002_0100);
    wr(`MDR_OFF_BUSCFG, 32'h0002_0101);
    idle(2);
    chk({31'h0, soft_rst}, 32'h0000_0001);
    wr(`MDR_OFF_BUSCFG, 32'h0002_0100);
    rdchk(`MDR_OFF_BUSCFG, 32'h0002_0101);
    pulse(0);
    idle(2);
    rdchk(`MDR_OFF_BUSCFG, 32'h0002_0100);
    chk({31'h0, soft_rst}, 32'h0000_0000);
    wr(`MDR_OFF_OPCFG, 32'h0000_2002);
    rdchk(`MDR_OFF_OPCFG, 32'h0000_2002);
    chk(op_cfg, 32'h0000_2002);
    pulse(1);
    idle(2);
    rdchk(`MDR_OFF_OPCFG, 32'h0000_0002);
    $display("self clear test done");
  endtask : t_swrst

  task automatic t_status();
    wr(`MDR_OFF_STATUS, 32'h0000_0000);
    pulse(2);
    pulse(3);
    idle(2);
    rdchk(`MDR_OFF_STATUS, 32'h8000_0010);
    wr(`MDR_OFF_STATUS, 32'h8000_0000);
    rdchk(`MDR_OFF_STATUS, 32'h8000_0010);
    wr(`MDR_OFF_STATUS, 32'h0000_0010);
    rdchk(`MDR_OFF_STATUS, 32'h0000_0000);
    rdchk(`MDR_OFF_MISSED, 32'h0001_0001);
    pulse(2);
    pulse(2);
    wr(`MDR_OFF_MISSED, 32'h0000_0000);
    rdchk(`MDR_OFF_MISSED, 32'h0001_0002);
    rdchk(`MDR_OFF_MISSED, 32'h0000_0000);
    $display("status test done");
  endtask : t_status

  // every event source has fired by now
  task automatic t_irq();
    rdchk(`MDR_OFF_EVTSTAT, 32'h0000_001F);
    wr(`MDR_OFF_EVTCLR, 32'h0000_001F);
    rdchk(`MDR_OFF_EVTSTAT, 32'h0000_0000);
    rdchk(`MDR_OFF_EVTCLR, 32'h0000_0000);
    wr(`MDR_OFF_EVTEN, 32'h0000_0010);
    rdchk(`MDR_OFF_EVTEN, 32'h0000_0010);
    pulse(2);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse(3);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`MDR_OFF_EVTEN, 32'h0000_0000);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`MDR_OFF_EVTEN, 32'h0000_0010);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`MDR_OFF_EVTCLR, 32'h0000_0010);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(`MDR_OFF_EVTSTAT, 32'h0000_0008);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_ptr();
    logic [15:0] adr [0:4];
    adr = '{`MDR_OFF_BUSSTAT, `MDR_OFF_CURTXD, `MDR_OFF_CURRXD,
            `MDR_OFF_CURTXB, `MDR_OFF_CURRXB};
    foreach (adr[i]) rdchk(adr[i], ptr_in[i]);
    wr(`MDR_OFF_CURTXD, 32'h0000_0000);
    rdchk(`MDR_OFF_CURTXD, ptr_in[1]);
    wr(`MDR_OFF_SYSTIME, 32'h1000_0000);
    repeat (3) pulse(4);
    idle(2);
    rdchk(`MDR_OFF_SYSTIME, 32'h1000_0003);
    $display("pointer and time test done");
  endtask : t_ptr

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ptr_in[0] <= 32'h0000_0005;
    ptr_in[1] <= 32'h2000_1A40;
    ptr_in[2] <= 32'h2000_2B80;
    ptr_in[3] <= 32'h2000_3C00;
    ptr_in[4] <= 32'h2000_4D00;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    idle(2);
    t_reset();
    t_rw();
    t_rsv();
    t_poll();
    t_swrst();
    t_status();
    t_irq();
    t_ptr();
    conclude();
  end
endmodule : mdr_regs_tb_top
